/* File: rtl/tbes_consts.vh */
// Purpose: shared constants of the ten-bit embedded clock serializer
// Assumes: included by bare name from the top design file only; the synchroniser does not include it
// Notes:   offsets are byte addresses on the apb register bus
`ifndef TBES_CONSTS_VH
`define TBES_CONSTS_VH

// =====================================================================
// register map
`define TBES_OFS_CTRL        8'h00
`define TBES_OFS_STATUS      8'h04
`define TBES_OFS_SYNC_COUNT  8'h08
`define TBES_OFS_LAST_WORD   8'h0c

// =====================================================================
// field positions
`define TBES_CTRL_SOFT_ALIGN 0
`define TBES_CTRL_RESYNC_EN  1
`define TBES_ST_LOCKED       0
`define TBES_ST_SYNCING      1
`define TBES_ST_DRIVING      2
`define TBES_ST_ASLEEP       3

// =====================================================================
// reset values
`define TBES_CTRL_RESET      2'h2

// =====================================================================
// framing and timing counts
`define TBES_WORD_BITS       10
`define TBES_FRAME_BITS      4'hc
`define TBES_SYNC_SYMBOL     12'h03f
`define TBES_MIN_SYNC        11'h400
`define TBES_LOCK_EDGES      510

`endif

/* File: rtl/tbes_sync.v */
// Purpose: two-stage synchroniser for a group of pin inputs
// Assumes: inputs are asynchronous to i_clock
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps

module tbes_sync #(
  parameter W = 1
) (
  input  wire         i_clock,
  input  wire         i_resetn,
  input  wire [W-1:0] i_async,
  output wire [W-1:0] o_sync
);

  // =====================================================================
  // per-bit flop pair
  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_r;
      reg stable_r;
      // two flops in series, synchronous reset
      always @(posedge i_clock) begin
        if (!i_resetn) begin
          meta_r   <= 1'b0;
          stable_r <= 1'b0;
        end else begin
          meta_r   <= i_async[g];
          stable_r <= meta_r;
        end
      end
      assign o_sync[g] = stable_r;
    end
  endgenerate

endmodule

/* File: rtl/tbes_top.v */
// Purpose: ten-bit serializer with embedded clock bits and alignment symbols
// Assumes: i_clock 10 MHz; transmit_clock and all pins sampled as plain inputs
// Notes:   one serial bit per i_clock cycle; a new active edge restarts the frame
`timescale 1ns/1ps
`include "tbes_consts.vh"

// Function
// - capture ten data bits each active edge
// - edge select high uses rising edge
// - edge select low uses falling edge
// - output enable low floats both outputs
// - sleep low stops pll, floats outputs
// - alignment request sends at least 1024 symbols
// - symbols continue while request stays high
// - two alignment requests are ORed together
// - negative output is complement of positive
// - frame wraps word with two clock bits
// - after float, resend symbols before data
module tbes_top #(
  parameter LOCK_EDGES = `TBES_LOCK_EDGES
) (
  input  wire        i_clock,
  input  wire        i_resetn,
  input  wire [9:0]  i_data,
  input  wire        i_strobe_edge_select,
  input  wire        i_transmit_clock,
  input  wire        i_serial_output_enable,
  input  wire        i_sleep_n,
  input  wire        i_align_request_a,
  input  wire        i_align_request_b,
  output reg         o_serial_p,
  output reg         o_serial_n,
  output reg         o_serial_oe,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [7:0]  i_paddr,
  input  wire [31:0] i_pwdata,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr
);

  // =====================================================================
  // pin synchronisers
  wire [15:0] pins_s;
  wire [9:0]  data_s;
  wire        edge_sel_s;
  wire        transmit_clock_s;
  wire        oe_s;
  wire        sleep_n_s;
  wire        req_a_s;
  wire        req_b_s;

  tbes_sync #(.W(16)) u_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_async  ({i_data, i_strobe_edge_select, i_transmit_clock, i_serial_output_enable,
                i_sleep_n, i_align_request_a, i_align_request_b}),
    .o_sync   (pins_s)
  );

  assign data_s     = pins_s[15:6];
  assign edge_sel_s = pins_s[5];
  assign transmit_clock_s     = pins_s[4];
  assign oe_s       = pins_s[3];
  assign sleep_n_s  = pins_s[2];
  assign req_a_s    = pins_s[1];
  assign req_b_s    = pins_s[0];

  // =====================================================================
  // state
  localparam ST_OFF  = 3'b001;
  localparam ST_LOCK = 3'b010;
  localparam ST_RUN  = 3'b100;

  reg [2:0]  state_r;
  reg [2:0]  state_nxt;
  reg        transmit_clock_d_r;
  reg [9:0]  hold_r;
  reg [11:0] lock_cnt_r;
  reg        syncing_r;
  reg [10:0] sync_cnt_r;
  reg [11:0] shift_r;
  reg [3:0]  bit_cnt_r;
  reg        drive_d_r;
  reg        float_seen_r;
  reg [1:0]  ctrl_r;

  wire rise_w   = transmit_clock_s & ~transmit_clock_d_r;
  wire fall_w   = ~transmit_clock_s & transmit_clock_d_r;
  // active edge chosen by edge select
  wire strobe_w = edge_sel_s ? rise_w : fall_w;
  wire asleep_w = ~sleep_n_s;
  // any request source starts symbols; lock flag of receiver may feed one
  wire req_w    = req_a_s | req_b_s | ctrl_r[`TBES_CTRL_SOFT_ALIGN];
  wire drive_w  = (state_r == ST_RUN) & oe_s;
  wire min_done = (sync_cnt_r >= `TBES_MIN_SYNC);

  // =====================================================================
  // pll model: off while asleep, locks after a count of edges
  always @* begin
    case (state_r)
      ST_OFF:  state_nxt = ST_LOCK;
      ST_LOCK: state_nxt = (lock_cnt_r >= LOCK_EDGES[11:0]) ? ST_RUN : ST_LOCK;
      ST_RUN:  state_nxt = ST_RUN;
      default: state_nxt = ST_OFF;
    endcase
    if (asleep_w) begin
      state_nxt = ST_OFF;
    end
  end

  always @(posedge i_clock) begin
    if (!i_resetn) begin
      state_r    <= ST_OFF;
      transmit_clock_d_r   <= 1'b0;
      lock_cnt_r <= 12'h000;
    end else begin
      state_r  <= state_nxt;
      transmit_clock_d_r <= transmit_clock_s;
      if (state_r != ST_LOCK) begin
        lock_cnt_r <= 12'h000;
      end else if (rise_w) begin
        lock_cnt_r <= lock_cnt_r + 12'h001;
      end
    end
  end

  // =====================================================================
  // word capture, alignment burst and serial shifter
  always @(posedge i_clock) begin
    if (!i_resetn) begin
      hold_r       <= 10'h000;
      syncing_r    <= 1'b0;
      sync_cnt_r   <= 11'h000;
      shift_r      <= 12'h000;
      bit_cnt_r    <= 4'h0;
      drive_d_r    <= 1'b0;
      float_seen_r <= 1'b1;
    end else begin
      drive_d_r <= drive_w;
      // a float period forces a fresh alignment burst
      if (!drive_w && ctrl_r[`TBES_CTRL_RESYNC_EN]) begin
        float_seen_r <= 1'b1;
      end else if (drive_w && !drive_d_r) begin
        float_seen_r <= 1'b0;
      end
      if (drive_w && !drive_d_r && float_seen_r) begin
        syncing_r  <= 1'b1;
        sync_cnt_r <= 11'h000;
      end else if (req_w && !syncing_r) begin
        syncing_r  <= 1'b1;
        sync_cnt_r <= 11'h000;
      end
      if (strobe_w) begin
        hold_r    <= data_s;
        bit_cnt_r <= `TBES_FRAME_BITS;
        if (syncing_r) begin
          shift_r <= `TBES_SYNC_SYMBOL;
          if (!min_done) begin
            sync_cnt_r <= sync_cnt_r + 11'h001;
          end else if (!req_w) begin
            syncing_r <= 1'b0;
          end
        end else begin
          // start bit high, ten data bits, stop bit low, lsb first
          shift_r <= {1'b0, data_s, 1'b1};
        end
      end else if (bit_cnt_r != 4'h0) begin
        shift_r   <= {1'b0, shift_r[11:1]};
        bit_cnt_r <= bit_cnt_r - 4'h1;
      end
    end
  end

  // =====================================================================
  // differential output stage
  always @(posedge i_clock) begin
    if (!i_resetn) begin
      o_serial_p  <= 1'b0;
      o_serial_n  <= 1'b1;
      o_serial_oe <= 1'b0;
    end else begin
      // sleep, pll not locked, or enable low floats the pair
      o_serial_oe <= drive_w;
      o_serial_p  <= shift_r[0];
      o_serial_n  <= ~shift_r[0];
    end
  end

  // =====================================================================
  // apb slave, one wait state
  wire acc_w = i_psel & i_penable;

  function [31:0] rd_mux;
    input [7:0] addr;
    begin
      case (addr)
        `TBES_OFS_CTRL:       rd_mux = {30'h0, ctrl_r};
        `TBES_OFS_STATUS:     rd_mux = {28'h0, asleep_w, o_serial_oe, syncing_r, state_r == ST_RUN};
        `TBES_OFS_SYNC_COUNT: rd_mux = {21'h0, sync_cnt_r};
        `TBES_OFS_LAST_WORD:  rd_mux = {22'h0, hold_r};
        default:              rd_mux = 32'h0;
      endcase
    end
  endfunction

  function mapped;
    input [7:0] addr;
    begin
      mapped = (addr == `TBES_OFS_CTRL) | (addr == `TBES_OFS_STATUS) |
               (addr == `TBES_OFS_SYNC_COUNT) | (addr == `TBES_OFS_LAST_WORD);
    end
  endfunction

  always @(posedge i_clock) begin
    if (!i_resetn) begin
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      ctrl_r    <= `TBES_CTRL_RESET;
    end else begin
      o_pready  <= acc_w & ~o_pready;
      o_pslverr <= acc_w & ~o_pready & ~mapped(i_paddr);
      if (acc_w && !o_pready && !i_pwrite) begin
        o_prdata <= rd_mux(i_paddr);
      end
      // write lands on the edge that sees pready
      if (acc_w && o_pready && i_pwrite && i_paddr == `TBES_OFS_CTRL) begin
        ctrl_r <= i_pwdata[1:0];
      end
    end
  end

endmodule

/* File: test/tbes_asserts.sv */
// Purpose: port checks of the serializer
// Assumes: pins reach the logic 2-3 clocks late
// Notes:   bound onto tbes_top
`timescale 1ns/1ps
// ======
// checker
module tbes_asserts #(
  parameter LOCK_EDGES = 4
) (
  input  wire i_clock,
  input  wire i_resetn,
  input  wire i_transmit_clock,
  input  wire i_serial_output_enable,
  input  wire i_sleep_n,
  input  wire i_align_request_a,
  input  wire i_align_request_b,
  input  wire i_psel,
  input  wire i_penable,
  input  wire o_serial_p,
  input  wire o_serial_n,
  input  wire o_serial_oe,
  input  wire o_pready
);
  reg  [15:0] edges_r;
  reg         transmit_clock_r;
  wire        req = i_align_request_a | i_align_request_b;
  // rising link clock edges since wake
  always @(posedge i_clock) begin
    transmit_clock_r <= i_transmit_clock;
    if (!i_resetn || !i_sleep_n)
      edges_r <= 16'h0000;
    else if (i_transmit_clock && !transmit_clock_r && edges_r != 16'hffff)
      edges_r <= edges_r + 16'h0001;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  sequence s_req_long;
    req [*8] ##1 req [*8];
  endsequence
  sequence s_symbol;
    o_serial_p [*6] ##1 !o_serial_p;
  endsequence
  chk_pair_compl: assert property (o_serial_oe |-> o_serial_n == !o_serial_p)
    else $error("pair not complementary");
  chk_sleep_float: assert property (!i_sleep_n [*5] |-> !o_serial_oe)
    else $error("driving while asleep");
  chk_den_float: assert property (!i_serial_output_enable [*4] |-> !o_serial_oe)
    else $error("driving while disabled");
  chk_sym_shape: assert property (s_req_long ##0 (o_serial_oe && $rose(o_serial_p)) |-> s_symbol)
    else $error("bad symbol");
  chk_lock_wait: assert property ($rose(o_serial_oe) |-> edges_r >= LOCK_EDGES)
    else $error("driving before lock");
  chk_reset_vals: assert property ($rose(i_resetn) |-> !o_serial_oe && !o_pready && o_serial_n)
    else $error("bad reset values");
  chk_ready_wait: assert property ($rose(i_psel && i_penable) |-> !o_pready ##1 o_pready)
    else $error("bad wait state");
  chk_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready too long");
endmodule

bind tbes_top tbes_asserts #(.LOCK_EDGES(LOCK_EDGES)) tbes_asserts_i (.i_clock, .i_resetn, .i_transmit_clock,
  .i_serial_output_enable, .i_sleep_n, .i_align_request_a, .i_align_request_b, .i_psel, .i_penable,
  .o_serial_p, .o_serial_n, .o_serial_oe, .o_pready);

/* File: test/tbes_rx_model.sv */
// Purpose: receiving end of the serial line
// Assumes: each frame opens with a rise, 8 bits long
// Notes:   lock flag active low, lost when line floats
`timescale 1ns/1ps
// ======
// receiver
module tbes_rx_model (
  input  wire        i_clock,
  input  wire        i_serial_p,
  input  wire        i_serial_oe,
  output reg         o_lock_n,
  output reg   [6:0] o_word,
  output reg  [15:0] o_syms,
  output reg  [15:0] o_words
);
  reg   [3:0] pos_r;
  reg   [5:0] sh_r;
  reg         last_r;
  initial begin
    {o_lock_n, pos_r, last_r, o_syms, o_words, sh_r, o_word} = {1'b1, 4'hf, 1'b0, 32'h0, 13'h0};
  end
  // frame decode, symbol count and lock
  always @(posedge i_clock) begin
    last_r <= i_serial_p;
    if (!i_serial_oe) begin
      o_lock_n <= 1'b1;
      pos_r    <= 4'hf;
    end else if (pos_r > 4'h6) begin
      if (i_serial_p && !last_r)
        pos_r <= 4'h0;
    end else begin
      sh_r  <= {i_serial_p, sh_r[5:1]};
      pos_r <= pos_r + 4'h1;
      if (pos_r == 4'h6 && sh_r == 6'h1f) begin
        o_syms <= o_syms + 16'h0001;
        if (o_syms[2])
          o_lock_n <= 1'b0;
      end else if (pos_r == 4'h6) begin
        o_words <= o_words + 16'h0001;
        o_word  <= {i_serial_p, sh_r};
      end
    end
  end
endmodule

/* File: test/tb_tbes_top.sv */
// Purpose: self-checking bench of the serializer
// Assumes: link clock 800 ns, lock after 4 edges
// Notes:   request b is the receiver lock flag
`timescale 1ns/1ps
// ======
// bench
module tb_tbes_top;
  reg         i_clock, i_resetn, i_transmit_clock, i_strobe_edge_select, i_serial_output_enable;
  reg         i_sleep_n, i_align_request_a, i_psel, i_penable, i_pwrite, err;
  reg   [9:0] i_data, wx, wy;
  reg   [7:0] i_paddr;
  reg  [31:0] i_pwdata, rd;
  wire        i_align_request_b, o_serial_p, o_serial_n, o_serial_oe, o_pready, o_pslverr;
  wire [31:0] o_prdata;
  wire  [6:0] word;
  wire [15:0] syms, words;
  integer     fail_count, n_tests, seed, k, cyc = 0;
  reg  [15:0] s0, w0;
  tbes_top #(.LOCK_EDGES(4)) tbes_top_i (.i_clock, .i_resetn, .i_data, .i_strobe_edge_select, .i_transmit_clock,
    .i_serial_output_enable, .i_sleep_n, .i_align_request_a, .i_align_request_b, .o_serial_p, .o_serial_n,
    .o_serial_oe, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr);
  tbes_rx_model tbes_rx_model_i (.i_clock, .i_serial_p(o_serial_p), .i_serial_oe(o_serial_oe),
    .o_lock_n(i_align_request_b), .o_word(word), .o_syms(syms), .o_words(words));
  // clocks and hang limit
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  initial begin
    i_transmit_clock = 1'b0;
    #137;
    forever #400 i_transmit_clock = ~i_transmit_clock;
  end
  always @(posedge i_clock) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end
  task complete_run;
    begin
      $display("tests %0d fails %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  // one apb transfer, held until pready
  task apb(input [7:0] a, input w, input [31:0] d);
    begin
      i_paddr <= a;
      i_pwrite <= w;
      i_pwdata <= d;
      i_psel <= 1'b1;
      @(posedge i_clock);
      i_penable <= 1'b1;
      @(posedge i_clock);
      while (o_pready !== 1'b1) begin
        @(posedge i_clock);
      end
      rd = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      // idle edge so the next call never re-raises psel in this step
      @(posedge i_clock);
    end
  endtask
  // wait for symbols then data, count the burst
  task burst(input [15:0] least);
    begin
      k = 0;
      w0 = words;
      while ((syms == s0 || words == w0) && k < 20000) begin
        if (syms == s0) w0 = words;
        k = k + 1;
        @(posedge i_clock);
      end
      chk({31'h0, syms - s0 >= least}, 32'h1);
    end
  endtask
  // data changes mid half period, one edge sees each word
  task edge_test(input s);
    begin
      i_strobe_edge_select <= s;
      repeat (3) begin
        wx = $random(seed) & 10'h3be;
        wy = $random(seed) & 10'h3be;
        @(posedge i_transmit_clock);
        repeat (2) @(posedge i_clock);
        i_data <= wx;
        @(negedge i_transmit_clock);
        repeat (2) @(posedge i_clock);
        i_data <= wy;
      end
      @(posedge i_transmit_clock);
      repeat (4) @(posedge i_clock);
      apb(8'h0c, 1'b0, 32'h0);
      chk(rd, {22'h0, s ? wy : wx});
      repeat (8) @(posedge i_clock);
      if (s) chk({25'h0, word}, {25'h0, wy[6:0]});
    end
  endtask
  // main sequence
  initial begin
    {seed, fail_count, n_tests} = {32'd83695, 64'h0};
    {i_resetn, i_data, i_strobe_edge_select, i_serial_output_enable, i_sleep_n} = 14'h007;
    {i_align_request_a, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = 44'h0;
    repeat (2) @(posedge i_clock);
    i_resetn <= 1'b1;
    apb(8'h00, 1'b0, 32'h0);
    chk(rd, 32'h2);
    apb(8'h10, 1'b0, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(8'h04, 1'b1, 32'hf);
    s0 = 16'h0;
    burst(16'h0400);
    apb(8'h04, 1'b0, 32'h0);
    chk(rd, 32'h5);
    edge_test(1'b1);
    edge_test(1'b0);
    s0 = syms;
    i_align_request_a <= 1'b1;
    repeat (16) @(posedge i_clock);
    i_align_request_a <= 1'b0;
    burst(16'h0400);
    s0 = syms;
    i_align_request_a <= 1'b1;
    repeat (10400) @(posedge i_clock);
    i_align_request_a <= 1'b0;
    burst(16'd1290);
    s0 = syms;
    i_serial_output_enable <= 1'b0;
    repeat (8) @(posedge i_clock);
    chk({31'h0, o_serial_oe}, 32'h0);
    i_serial_output_enable <= 1'b1;
    burst(16'h0400);
    s0 = syms;
    i_sleep_n <= 1'b0;
    repeat (8) @(posedge i_clock);
    apb(8'h04, 1'b0, 32'h0);
    chk({rd[3:2], o_serial_oe}, 3'b100);
    i_sleep_n <= 1'b1;
    burst(16'h0400);
    complete_run;
  end
endmodule
